// >>> pkg/adcf_regs.svh
// register offsets, field positions, reset values and timing constants of the result formatter
`ifndef ADCF_REGS_SVH
`define ADCF_REGS_SVH
`define ADCF_OFS_RES_HI 8'h00
`define ADCF_OFS_RES_LO 8'h04
`define ADCF_OFS_CLK_CFG 8'h08
`define ADCF_OFS_IRQ_STAT 8'h0c
`define ADCF_OFS_IRQ_MASK 8'h10
`define ADCF_CFG_PS_HI 7
`define ADCF_CFG_PS_LO 5
`define ADCF_CFG_SRC 4
`define ADCF_CFG_MODE_HI 3
`define ADCF_CFG_MODE_LO 2
`define ADCF_CFG_RESET 8'h04
`define ADCF_CFG_WMASK 8'hfc
`define ADCF_IRQ_DONE 0
`define ADCF_IRQ_LOST 1
`define ADCF_IRQ_W 2
`define ADCF_PS_MAX 3'h4
`define ADCF_RESP_OKAY 2'h0
`define ADCF_RESP_SLVERR 2'h2
`endif

// >>> pkg/adcf_pkg.sv
// types shared by the result formatter
`default_nettype none
package adcf_pkg;
  // placement of the 10-bit result in the two result bytes
  typedef enum logic [1:0] {
    ADCF_TRUNC,
    ADCF_RIGHT,
    ADCF_LEFT,
    ADCF_LSIGNED
  } adcf_mode_type;
endpackage
`default_nettype wire

// >>> hdl/adcf_top.sv
// converter result formatting, read interlock, clock prescaler and axi4-lite registers
// Summary of operation
// - signed left mode: high byte is top eight bits, top bit inverted
// - signed left mode: low byte holds two lsbs at top, rest zero
// - justified modes: both bytes refresh on each finished conversion not dropped by the interlock
// - justified modes: reading high byte freezes low byte until low read
// - while high read pends without low read, new results are dropped
// - truncation: low byte holds eight msbs, high byte reads zero
// - truncation: low byte refreshes every conversion, no interlock
// - prescale field divides input clock by 1, 2, 4, 8, or 16
// - source bit set picks bus clock, clear picks oscillator; reset clear
// - justify field: 00 trunc, 01 right, 10 left, 11 left signed
// - reset returns justify field to right justified
// - right mode: high byte has two msbs, low byte eight lsbs
// - unsigned left mode: high byte eight msbs, low byte two lsbs
// - done flag stays set until the result data register is read
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "adcf_regs.svh"
module adcf_top (
  // clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // converter side
  input wire logic CONV_DONE_I,
  input wire logic [9:0] CONV_RESULT_I,
  input wire logic OSC_CLK_I,
  output logic ADC_CLK_EN_O,
  output logic CONV_DONE_FLAG_O,
  output logic IRQ_O,
  // axi4-lite write
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_q, rst_n;
  // async assert, release through two flops
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, bvld_q, bvld_d, wstb_q, wstb_d;
  logic [7:0] waddr_q, waddr_d, wdat_q, wdat_d, cfg_q, cfg_d, hi_q, hi_d, lo_q, lo_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic arrdy_q, arrdy_d, rvld_q, rvld_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_go, rd_go;
  logic [`ADCF_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
  // address and data may come in either order; the write happens once both are held
  assign wr_go = !awrdy_q && !wrdy_q && !bvld_q;
  assign rd_go = S_AXI_ARVALID && arrdy_q;
  always_comb begin
    awrdy_d = awrdy_q;
    wrdy_d = wrdy_q;
    bvld_d = bvld_q;
    waddr_d = waddr_q;
    wdat_d = wdat_q;
    wstb_d = wstb_q;
    bresp_d = bresp_q;
    if (S_AXI_AWVALID && awrdy_q) begin
      awrdy_d = 1'b0;
      waddr_d = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && wrdy_q) begin
      wrdy_d = 1'b0;
      wdat_d = S_AXI_WDATA[7:0];
      wstb_d = S_AXI_WSTRB[0];
    end
    if (wr_go) begin
      bvld_d = 1'b1;
      bresp_d = (waddr_q == `ADCF_OFS_CLK_CFG || waddr_q == `ADCF_OFS_IRQ_MASK) ?
                `ADCF_RESP_OKAY : `ADCF_RESP_SLVERR;
    end
    if (bvld_q && S_AXI_BREADY) begin
      bvld_d = 1'b0;
      awrdy_d = 1'b1;
      wrdy_d = 1'b1;
    end
  end
  // read answer is built at the address handshake so side effects happen once
  always_comb begin
    arrdy_d = arrdy_q;
    rvld_d = rvld_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_go) begin
      arrdy_d = 1'b0;
      rvld_d = 1'b1;
      rresp_d = `ADCF_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `ADCF_OFS_RES_HI: rdata_d = {24'h0, hi_q};
        `ADCF_OFS_RES_LO: rdata_d = {24'h0, lo_q};
        `ADCF_OFS_CLK_CFG: rdata_d = {24'h0, cfg_q};
        `ADCF_OFS_IRQ_STAT: rdata_d = {30'h0, stat_q};
        `ADCF_OFS_IRQ_MASK: rdata_d = {30'h0, mask_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = `ADCF_RESP_SLVERR;
        end
      endcase
    end
    if (rvld_q && S_AXI_RREADY) begin
      rvld_d = 1'b0;
      arrdy_d = 1'b1;
    end
  end
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
      bvld_q <= 1'b0;
      waddr_q <= 8'h0;
      wdat_q <= 8'h0;
      wstb_q <= 1'b0;
      bresp_q <= `ADCF_RESP_OKAY;
      arrdy_q <= 1'b1;
      rvld_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `ADCF_RESP_OKAY;
    end else begin
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
      bvld_q <= bvld_d;
      waddr_q <= waddr_d;
      wdat_q <= wdat_d;
      wstb_q <= wstb_d;
      bresp_q <= bresp_d;
      arrdy_q <= arrdy_d;
      rvld_q <= rvld_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
  assign S_AXI_AWREADY = awrdy_q;
  assign S_AXI_WREADY = wrdy_q;
  assign S_AXI_BVALID = bvld_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arrdy_q;
  assign S_AXI_RVALID = rvld_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  // ------------------------------------------------------------
  // result formatting and interlock
  // ------------------------------------------------------------
  adcf_pkg::adcf_mode_type mode;
  logic rd_hi, rd_lo, lock_q, lock_d, take, flag_q, flag_d, irq_q, irq_d;
  assign mode = adcf_pkg::adcf_mode_type'(cfg_q[`ADCF_CFG_MODE_HI:`ADCF_CFG_MODE_LO]);
  assign rd_hi = rd_go && S_AXI_ARADDR == `ADCF_OFS_RES_HI;
  assign rd_lo = rd_go && S_AXI_ARADDR == `ADCF_OFS_RES_LO;
  // a result landing with the high read is dropped, else the low byte would no longer pair with it
  assign take = CONV_DONE_I && (mode == adcf_pkg::ADCF_TRUNC || !(lock_q || rd_hi));
  always_comb begin
    hi_d = hi_q;
    lo_d = lo_q;
    lock_d = lock_q;
    if (take) begin
      unique case (mode)
        adcf_pkg::ADCF_TRUNC: begin
          hi_d = 8'h0;
          lo_d = CONV_RESULT_I[9:2];
        end
        adcf_pkg::ADCF_RIGHT: begin
          hi_d = {6'h0, CONV_RESULT_I[9:8]};
          lo_d = CONV_RESULT_I[7:0];
        end
        adcf_pkg::ADCF_LEFT: begin
          hi_d = CONV_RESULT_I[9:2];
          lo_d = {CONV_RESULT_I[1:0], 6'h0};
        end
        adcf_pkg::ADCF_LSIGNED: begin
          hi_d = {~CONV_RESULT_I[9], CONV_RESULT_I[8:2]};
          lo_d = {CONV_RESULT_I[1:0], 6'h0};
        end
      endcase
    end
    // a high read arms the lock, a low read releases it; truncation never locks
    if (rd_hi) lock_d = 1'b1;
    if (rd_lo || mode == adcf_pkg::ADCF_TRUNC) lock_d = 1'b0;
  end
  // done flag: a new conversion wins over the clearing read
  always_comb begin
    flag_d = flag_q;
    if (rd_hi || rd_lo) flag_d = 1'b0;
    if (CONV_DONE_I) flag_d = 1'b1;
  end
  // sticky events: read of status clears, an event in the same cycle survives
  always_comb begin
    stat_d = stat_q;
    if (rd_go && S_AXI_ARADDR == `ADCF_OFS_IRQ_STAT) stat_d = '0;
    if (take) stat_d[`ADCF_IRQ_DONE] = 1'b1;
    if (CONV_DONE_I && !take) stat_d[`ADCF_IRQ_LOST] = 1'b1;
    irq_d = |(stat_d & mask_d);
  end
  // configuration and mask writes, low byte lane only
  always_comb begin
    cfg_d = cfg_q;
    mask_d = mask_q;
    if (wr_go && wstb_q && waddr_q == `ADCF_OFS_CLK_CFG) cfg_d = wdat_q & `ADCF_CFG_WMASK;
    if (wr_go && wstb_q && waddr_q == `ADCF_OFS_IRQ_MASK) mask_d = wdat_q[`ADCF_IRQ_W-1:0];
  end
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      hi_q <= 8'h0;
      lo_q <= 8'h0;
      lock_q <= 1'b0;
      flag_q <= 1'b0;
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
      cfg_q <= `ADCF_CFG_RESET;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      lock_q <= lock_d;
      flag_q <= flag_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      cfg_q <= cfg_d;
    end
  end
  assign CONV_DONE_FLAG_O = flag_q;
  assign IRQ_O = irq_q;

  // ------------------------------------------------------------
  // converter clock prescaler
  // ------------------------------------------------------------
  // the oscillator is sampled, so it must run below half the bus clock
  logic osc_q, tick, en_q, en_d;
  logic [2:0] ps;
  logic [3:0] cnt_q, cnt_d, last;
  assign ps = cfg_q[`ADCF_CFG_PS_HI:`ADCF_CFG_PS_LO];
  assign tick = cfg_q[`ADCF_CFG_SRC] ? 1'b1 : (OSC_CLK_I && !osc_q);
  assign last = 4'((5'h1 << ((ps > `ADCF_PS_MAX) ? `ADCF_PS_MAX : ps)) - 5'h1);
  always_comb begin
    cnt_d = cnt_q;
    en_d = 1'b0;
    if (tick) begin
      en_d = (cnt_q >= last);
      cnt_d = en_d ? 4'h0 : cnt_q + 4'h1;
    end
  end
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= 1'b0;
      cnt_q <= 4'h0;
      en_q <= 1'b0;
    end else begin
      osc_q <= OSC_CLK_I;
      cnt_q <= cnt_d;
      en_q <= en_d;
    end
  end
  assign ADC_CLK_EN_O = en_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);
  property p_signed_hi;
    take && mode == adcf_pkg::ADCF_LSIGNED |=> hi_q == {~$past(CONV_RESULT_I[9]), $past(CONV_RESULT_I[8:2])};
  endproperty
  a_signed_hi: assert property (p_signed_hi) else $error("signed high byte wrong");
  property p_left_lo;
    take && mode[1] |=> lo_q == {$past(CONV_RESULT_I[1:0]), 6'h0};
  endproperty
  a_left_lo: assert property (p_left_lo) else $error("left low byte wrong");
  property p_trunc;
    take && mode == adcf_pkg::ADCF_TRUNC |=> hi_q == 8'h0 && lo_q == $past(CONV_RESULT_I[9:2]);
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncation placement wrong");
  property p_right;
    take && mode == adcf_pkg::ADCF_RIGHT |=> {hi_q, lo_q} == {6'h0, $past(CONV_RESULT_I)};
  endproperty
  a_right: assert property (p_right) else $error("right placement wrong");
  sequence s_hi_read;
    rd_hi && mode != adcf_pkg::ADCF_TRUNC && !rd_lo;
  endsequence
  sequence s_conv_held;
    CONV_DONE_I && !rd_lo && mode != adcf_pkg::ADCF_TRUNC;
  endsequence
  property p_lock;
    s_hi_read ##1 s_conv_held |=> $stable(hi_q) && $stable(lo_q);
  endproperty
  a_lock: assert property (p_lock) else $error("result changed while interlocked");
  property p_trunc_nolock;
    mode == adcf_pkg::ADCF_TRUNC |=> !lock_q || mode != adcf_pkg::ADCF_TRUNC;
  endproperty
  a_trunc_nolock: assert property (p_trunc_nolock) else $error("truncation mode locked");
  property p_div2;
    en_q && cfg_q[`ADCF_CFG_SRC] && ps == 3'h1 && $stable(cfg_q) ##1 $stable(cfg_q) |-> !en_q ##1 en_q;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two spacing wrong");
  property p_reset_cfg;
    $rose(rst_n) |-> cfg_q == `ADCF_CFG_RESET;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("config reset value wrong");
  property p_flag;
    CONV_DONE_I |=> flag_q;
  endproperty
  a_flag: assert property (p_flag) else $error("done flag not set");
  property p_flag_hold;
    !CONV_DONE_I |=> flag_q == ($past(flag_q) && !$past(rd_hi) && !$past(rd_lo));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("done flag held or cleared wrongly");
endmodule
`default_nettype wire

// >>> testbench/adcf_conv_model.sv
// converter model: done pulses, raw results and oscillator clock
`timescale 1ns/100ps
`default_nettype none
module adcf_conv_model (
  // bus clock and request from the bench
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [9:0] val_i,
  // converter side of the formatter
  output logic done_o,
  output logic [9:0] result_o,
  output logic osc_clk_o
);
  logic [1:0] div_q;
  initial begin
    done_o = 1'b0;
    result_o = 10'h155;
    osc_clk_o = 1'b0;
    div_q = 2'h0;
  end
  // result valid with the pulse only; a flipping pattern exposes stale sampling
  always @(posedge clk_i) begin
    done_o <= req_i;
    result_o <= req_i ? val_i : ~result_o;
  end
  // oscillator at an eighth of the bus clock, fast enough for the converter
  always @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) osc_clk_o <= ~osc_clk_o;
  end
endmodule
`default_nettype wire

// >>> testbench/adcf_top_tb_top.sv
// self-checking bench for the result formatter
`timescale 1ns/100ps
`default_nettype none
`include "adcf_regs.svh"
module adcf_top_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0;
  logic [9:0] val = 10'h000;
  logic [9:0] res;
  logic done, osc, en, flag, irq, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  int err_count = 0;
  int samples_checked = 0;
  // 125 MHz bus clock
  always #4 clk = ~clk;
  adcf_conv_model conv_model (.clk_i(clk), .req_i(req), .val_i(val), .done_o(done), .result_o(res),
    .osc_clk_o(osc));
  adcf_top DUT (.CLK_I(clk), .ARST_N_I(rst_n), .CONV_DONE_I(done), .CONV_RESULT_I(res), .OSC_CLK_I(osc),
    .ADC_CLK_EN_O(en), .CONV_DONE_FLAG_O(flag), .IRQ_O(irq), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    d = 32'hffffffff;
    r = 2'h3;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
    chk($sformatf("register %h", a), exp, d);
    chk("read response", {30'h0, er}, {30'h0, r});
  endtask
  // one conversion, then settle so registered flags can be sampled
  task automatic conv(input logic [9:0] v);
    @(posedge clk);
    req <= 1'b1;
    val <= v;
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // pulse count in a 64-cycle window, after a config change has settled
  task automatic meas(input int exp);
    int c;
    c = 0;
    repeat (40) @(negedge clk);
    repeat (64) begin
      @(negedge clk);
      if (en === 1'b1) c++;
    end
    chk("clock enables", exp, c);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc(`ADCF_OFS_CLK_CFG, 32'h04, `ADCF_RESP_OKAY);
    chk("done flag", 32'h0, {31'h0, flag});
  endtask
  task automatic t_modes;
    logic [9:0] r;
    logic [7:0] eh, el;
    r = 10'h2c5;
    for (int m = 0; m < 4; m++) begin
      wr(`ADCF_OFS_CLK_CFG, 32'h10 | m << 2, `ADCF_RESP_OKAY);
      conv(r);
      chk("done flag", 32'h1, {31'h0, flag});
      eh = (m == 0) ? 8'h00 : (m == 1) ? {6'h00, r[9:8]} : {r[9] ^ m[0], r[8:2]};
      el = (m == 0) ? r[9:2] : (m == 1) ? r[7:0] : {r[1:0], 6'h00};
      rdc(`ADCF_OFS_RES_HI, {24'h0, eh}, `ADCF_RESP_OKAY);
      rdc(`ADCF_OFS_RES_LO, {24'h0, el}, `ADCF_RESP_OKAY);
      repeat (2) @(negedge clk);
      chk("done flag", 32'h0, {31'h0, flag});
      r = ~r;
    end
  endtask
  // a high read locks out the next result; only the lost event is unmasked
  task automatic t_lock;
    wr(`ADCF_OFS_IRQ_MASK, 32'h2, `ADCF_RESP_OKAY);
    wr(`ADCF_OFS_CLK_CFG, 32'h14, `ADCF_RESP_OKAY);
    conv(10'h3a7);
    rdc(`ADCF_OFS_RES_HI, 32'h3, `ADCF_RESP_OKAY);
    chk("irq", 32'h0, {31'h0, irq});
    conv(10'h0f0);
    chk("irq", 32'h1, {31'h0, irq});
    rdc(`ADCF_OFS_RES_LO, 32'ha7, `ADCF_RESP_OKAY);
    rdc(`ADCF_OFS_RES_HI, 32'h3, `ADCF_RESP_OKAY);
    rdc(`ADCF_OFS_RES_LO, 32'ha7, `ADCF_RESP_OKAY);
    rdc(`ADCF_OFS_IRQ_STAT, 32'h3, `ADCF_RESP_OKAY);
    repeat (2) @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    rdc(`ADCF_OFS_IRQ_STAT, 32'h0, `ADCF_RESP_OKAY);
  endtask
  task automatic t_trunc;
    wr(`ADCF_OFS_CLK_CFG, 32'h10, `ADCF_RESP_OKAY);
    conv(10'h155);
    rdc(`ADCF_OFS_RES_HI, 32'h0, `ADCF_RESP_OKAY);
    conv(10'h2aa);
    rdc(`ADCF_OFS_RES_LO, 32'haa, `ADCF_RESP_OKAY);
  endtask
  // unmapped and read-only places, reserved config bits
  task automatic t_bus;
    rdc(8'h14, 32'h0, `ADCF_RESP_SLVERR);
    wr(`ADCF_OFS_RES_HI, 32'hff, `ADCF_RESP_SLVERR);
    wr(`ADCF_OFS_CLK_CFG, 32'h17, `ADCF_RESP_OKAY);
    rdc(`ADCF_OFS_CLK_CFG, 32'h14, `ADCF_RESP_OKAY);
  endtask
  task automatic t_prescale;
    for (int n = 0; n < 6; n++) begin
      wr(`ADCF_OFS_CLK_CFG, 32'h14 | n << 5, `ADCF_RESP_OKAY);
      meas(64 >> (n > 4 ? 4 : n));
    end
    wr(`ADCF_OFS_CLK_CFG, 32'h04, `ADCF_RESP_OKAY);
    meas(8);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_modes();
    t_lock();
    t_trunc();
    t_bus();
    t_prescale();
    end_of_test();
  end
  // watchdog well beyond the under one thousand cycles the run needs
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
